// file: bsw_defs.svh
// default figures and reset values for the burst sliding window block
`ifndef BSW_DEFS_SVH
`define BSW_DEFS_SVH
`define BSW_MAX_BURST  4
`define BSW_MAX_SEQ    10
`define BSW_DATA_W     32
`define BSW_RX_BUFS    8
`define BSW_FIFO_DEPTH 16
`define BSW_SEQ_START  0
`endif

// file: bsw_link_peer.sv
// link peer model that takes burst packets from the endpoint
`timescale 1ns/1ps
module bsw_link_peer #(
    parameter int SW = 4,
    parameter int DW = 32
) (
    input  wire logic          i_sys_clk,
    input  wire logic          i_slow,
    input  wire logic          i_pkt_valid,
    input  wire logic [SW-1:0] i_pkt_seq,
    input  wire logic [DW-1:0] i_pkt_data,
    output logic               o_pkt_ready
);
    logic [SW+DW-1:0] log_q[$];
    logic             odd_q = 1'h0;
    // slow mode refuses every other cycle, stretching the data phase
    always @(posedge i_sys_clk)
    begin
        odd_q <= ~odd_q;
        if (i_pkt_valid && o_pkt_ready)
            log_q.push_back({i_pkt_seq, i_pkt_data});
    end
    assign o_pkt_ready = !i_slow || odd_q;
endmodule // bsw_link_peer

// file: bsw_pkg.sv
// shared types for the burst sliding window block
package bsw_pkg;
    typedef enum logic [1:0] {
        TX_IDLE = 2'h0,
        TX_SCAN = 2'h1,
        TX_SEND = 2'h2
    } tx_state_t;
endpackage

// file: burst_sliding_window.sv
// burst sliding window endpoint with its in-order delivery fifo
`timescale 1ns/1ps
`include "bsw_defs.svh"

// ==========================================================
// delivery fifo
module bsw_fifo #(
    parameter int W     = `BSW_DATA_W,
    parameter int DEPTH = `BSW_FIFO_DEPTH
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_nrst,
    input  wire logic         i_wr_valid,
    output logic              o_wr_ready,
    input  wire logic [W-1:0] i_wr_data,
    output logic              o_rd_valid,
    input  wire logic         i_rd_ready,
    output logic [W-1:0]      o_rd_data,
    output logic [$clog2(DEPTH+1)-1:0] o_count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("fifo depth must be a power of two of at least 2");
    end
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [CW-1:0]           cnt;
    } fifo_st_t;
    fifo_st_t s_q;
    fifo_st_t s_d;
    logic     push;
    logic     pop;
    // honest flags straight from the occupancy count
    assign o_wr_ready = (s_q.cnt != CW'(DEPTH));
    assign o_rd_valid = (s_q.cnt != '0);
    assign o_rd_data  = s_q.mem[s_q.rp];
    assign o_count    = s_q.cnt;
    assign push       = i_wr_valid && o_wr_ready;
    assign pop        = o_rd_valid && i_rd_ready;
    // pointer and count update
    always_comb
    begin
        s_d = s_q;
        if (push)
        begin
            s_d.mem[s_q.wp] = i_wr_data;
            s_d.wp          = s_q.wp + AW'(1);
        end
        if (pop)
            s_d.rp = s_q.rp + AW'(1);
        if (push && !pop)
            s_d.cnt = s_q.cnt + CW'(1);
        else if (pop && !push)
            s_d.cnt = s_q.cnt - CW'(1);
    end
    // state register
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            s_q <= '0;
        else
            s_q <= s_d;
    end
endmodule // bsw_fifo

// ==========================================================
// sliding window endpoint
// How it works
// - window span never exceeds max sequence distance, which is max seq - 1.
// - distance counts from oldest outstanding seq to newest window seq.
// - receiver drops arriving packets whose seq is outside its window.
// - neither window ever holds more than max burst entries; the code caps only the receive window, transmit copies any ack.
// - configuration event restarts sequences at zero, windows at full burst.
// - packets sent are the smaller of pending data and receive window.
// - transmitter sends every window packet and nothing outside it.
// - receive window slides one per packet received, modulo max sequence.
// - OUT acks go in handshake payload, IN acks in next schedule slot.
// - acknowledgement is a bitmask, ones mark seqs accepted next.
// - intact ack replaces transmit window; no ack leaves it unchanged. The code ignores any ack that arrives during a data phase.
// - max sequence value must be at least twice max burst.
// - receiver records got packets, keeps window over still-missing ones.
// - lost packets resent with original seq, retries before new data.
// - clean next IN token proves the previous ack was received.
// - stuck oldest packet limits window to distance; transmitter mirrors.
// - sequence numbers run from zero to max sequence minus one.
// - new data segments take strictly ascending sequence numbers.
module burst_sliding_window #(
    parameter int MAX_BURST  = `BSW_MAX_BURST,
    parameter int MAX_SEQ    = `BSW_MAX_SEQ,
    parameter int DW         = `BSW_DATA_W,
    parameter int RX_BUFS    = `BSW_RX_BUFS,
    parameter int FIFO_DEPTH = `BSW_FIFO_DEPTH
) (
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_nrst,
    input  wire logic                       i_win_reset,
    input  wire logic                       i_rx_valid,
    input  wire logic                       i_rx_ok,
    input  wire logic [$clog2(MAX_SEQ)-1:0] i_rx_seq,
    input  wire logic [DW-1:0]              i_rx_data,
    output logic [MAX_SEQ-1:0]              o_ack_vec,
    output logic                            o_ack_zero,
    output logic                            o_up_valid,
    input  wire logic                       i_up_ready,
    output logic [DW-1:0]                   o_up_data,
    input  wire logic                       i_tx_valid,
    output logic                            o_tx_ready,
    input  wire logic [DW-1:0]              i_tx_data,
    input  wire logic                       i_ack_valid,
    input  wire logic [MAX_SEQ-1:0]         i_ack_vec,
    input  wire logic                       i_send_start,
    output logic                            o_send_busy,
    output logic                            o_pkt_valid,
    input  wire logic                       i_pkt_ready,
    output logic [$clog2(MAX_SEQ)-1:0]      o_pkt_seq,
    output logic [DW-1:0]                   o_pkt_data
);
    localparam int SW = $clog2(MAX_SEQ);
    localparam int CW = $clog2(MAX_SEQ+1);
    localparam int FC = $clog2(FIFO_DEPTH+1);
    localparam logic [MAX_SEQ-1:0] INIT_WIN =
        MAX_SEQ'((64'h1 << MAX_BURST) - 64'h1);
    initial
    begin
        if (MAX_SEQ < 2 * MAX_BURST || MAX_BURST < 1)
            $error("max sequence must be at least twice max burst");
        if (RX_BUFS < MAX_BURST || MAX_SEQ > 64)
            $error("buffer count or sequence range not supported");
    end
    typedef struct packed {
        logic [SW-1:0]              rx_base;
        logic [MAX_SEQ-1:0]         rx_got;
        logic [MAX_SEQ-1:0]         rx_win;
        logic [MAX_SEQ-1:0][DW-1:0] rx_mem;
        logic [SW-1:0]              tx_base;
        logic [SW-1:0]              tx_next;
        logic [MAX_SEQ-1:0]         tx_win;
        logic [MAX_SEQ-1:0]         tx_held;
        logic [MAX_SEQ-1:0][DW-1:0] tx_mem;
        bsw_pkg::tx_state_t         tx_st;
        logic [SW-1:0]              tx_idx;
        logic [CW-1:0]              tx_cnt;
        logic [SW-1:0]              pkt_seq;
        logic [DW-1:0]              pkt_data;
    } bsw_st_t;
    bsw_st_t        s_q;
    bsw_st_t        s_d;
    logic           up_wr_ready;
    logic           release_ok;
    logic [FC-1:0]  fifo_cnt;
    // position k steps after a base, wrapped into the sequence range
    function automatic logic [SW-1:0] seq_at(input logic [SW-1:0] b,
                                             input int k);
        int v;
        v = (int'(b) + k) % MAX_SEQ;
        return SW'(v);
    endfunction
    // oldest buffered packet goes upward only when it is next in order
    assign release_ok = s_q.rx_got[s_q.rx_base] && up_wr_ready;
    bsw_fifo #(
        .W     (DW),
        .DEPTH (FIFO_DEPTH)
    ) u_up_fifo (
        .i_sys_clk  (i_sys_clk),
        .i_nrst     (i_nrst),
        .i_wr_valid (release_ok),
        .o_wr_ready (up_wr_ready),
        .i_wr_data  (s_q.rx_mem[s_q.rx_base]),
        .o_rd_valid (o_up_valid),
        .i_rd_ready (i_up_ready),
        .o_rd_data  (o_up_data),
        .o_count    (fifo_cnt)
    );

    // acknowledgement goes out from a register; the caller places it in
    // the handshake payload (OUT) or the next token (IN)
    assign o_ack_vec   = s_q.rx_win;
    assign o_ack_zero  = (s_q.rx_win == '0);
    assign o_send_busy = (s_q.tx_st != bsw_pkg::TX_IDLE);
    assign o_pkt_valid = (s_q.tx_st == bsw_pkg::TX_SEND);
    assign o_pkt_seq   = s_q.pkt_seq;
    assign o_pkt_data  = s_q.pkt_data;
    // new data only takes a free slot of the granted window, in order
    assign o_tx_ready  = (s_q.tx_st == bsw_pkg::TX_IDLE) && !i_ack_valid
                         && s_q.tx_win[s_q.tx_next]
                         && !s_q.tx_held[s_q.tx_next];

    // ======================================================
    // next state
    always_comb
    begin
        int          free;
        int          n;
        int          lim;
        logic        found;
        logic [SW-1:0] idx;
        free  = 0;
        n     = 0;
        lim   = 0;
        found = 1'b0;
        idx   = '0;
        s_d   = s_q;

        // receive side: land packets inside the window only
        if (i_rx_valid && i_rx_ok && s_q.rx_win[i_rx_seq])
        begin
            s_d.rx_got[i_rx_seq] = 1'b1;
            s_d.rx_mem[i_rx_seq] = i_rx_data;
        end
        if (release_ok)
        begin
            s_d.rx_got[s_q.rx_base] = 1'b0;
            s_d.rx_base = seq_at(s_q.rx_base, 1);
        end

        // window offers only free buffers, at most one burst; the scan
        // stops one short of the full range so the span never wraps
        free = RX_BUFS - int'(fifo_cnt);
        for (int k = 0; k < MAX_SEQ; k++)
            if (s_d.rx_got[k])
                free = free - 1;
        lim = (free < MAX_BURST) ? free : MAX_BURST;
        s_d.rx_win = '0;
        for (int k = 0; k < MAX_SEQ - 1; k++)
        begin
            idx = seq_at(s_d.rx_base, k);
            if (!s_d.rx_got[idx] && n < lim)
            begin
                s_d.rx_win[idx] = 1'b1;
                n = n + 1;
            end
        end

        // intact ack replaces the window while idle; anything outside it is done
        if (i_ack_valid && s_q.tx_st == bsw_pkg::TX_IDLE)
        begin
            s_d.tx_win  = i_ack_vec;
            s_d.tx_held = s_q.tx_held & i_ack_vec;
            s_d.tx_base = s_q.tx_next;
            for (int k = 0; k < MAX_SEQ; k++)
            begin
                idx = seq_at(s_q.tx_base, k);
                if (!found && i_ack_vec[idx])
                begin
                    s_d.tx_base = idx;
                    found = 1'b1;
                end
            end
        end
        else if (o_tx_ready && i_tx_valid)
        begin
            s_d.tx_mem[s_q.tx_next]  = i_tx_data;
            s_d.tx_held[s_q.tx_next] = 1'b1;
            s_d.tx_next = seq_at(s_q.tx_next, 1);
        end

        // data phase: scan from the oldest seq so retries lead new data
        case (s_q.tx_st)
            bsw_pkg::TX_IDLE:
            begin
                if (i_send_start && !i_ack_valid)
                begin
                    s_d.tx_st  = bsw_pkg::TX_SCAN;
                    s_d.tx_idx = s_q.tx_base;
                    s_d.tx_cnt = '0;
                end
            end
            bsw_pkg::TX_SCAN:
            begin
                if (s_q.tx_held[s_q.tx_idx] && s_q.tx_win[s_q.tx_idx])
                begin
                    s_d.pkt_seq  = s_q.tx_idx;
                    s_d.pkt_data = s_q.tx_mem[s_q.tx_idx];
                    s_d.tx_st    = bsw_pkg::TX_SEND;
                end
                else if (s_q.tx_cnt == CW'(MAX_SEQ - 1))
                    s_d.tx_st = bsw_pkg::TX_IDLE;
                else
                begin
                    s_d.tx_idx = seq_at(s_q.tx_idx, 1);
                    s_d.tx_cnt = s_q.tx_cnt + CW'(1);
                end
            end
            bsw_pkg::TX_SEND:
            begin
                // sent packets stay held until an ack drops them
                if (i_pkt_ready)
                begin
                    if (s_q.tx_cnt == CW'(MAX_SEQ - 1))
                        s_d.tx_st = bsw_pkg::TX_IDLE;
                    else
                    begin
                        s_d.tx_st  = bsw_pkg::TX_SCAN;
                        s_d.tx_idx = seq_at(s_q.tx_idx, 1);
                        s_d.tx_cnt = s_q.tx_cnt + CW'(1);
                    end
                end
            end
            default:
                s_d.tx_st = bsw_pkg::TX_IDLE;
        endcase

        // configuration event wins over everything else this cycle;
        // data already released upward stays in the fifo
        if (i_win_reset)
        begin
            s_d.rx_base = SW'(`BSW_SEQ_START);
            s_d.rx_got  = '0;
            s_d.rx_win  = INIT_WIN;
            s_d.tx_base = SW'(`BSW_SEQ_START);
            s_d.tx_next = SW'(`BSW_SEQ_START);
            s_d.tx_win  = INIT_WIN;
            s_d.tx_held = '0;
            s_d.tx_st   = bsw_pkg::TX_IDLE;
        end
    end
    // state register
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            s_q        <= '0;
            s_q.rx_win <= INIT_WIN;
            s_q.tx_win <= INIT_WIN;
            s_q.tx_st  <= bsw_pkg::TX_IDLE;
        end
        else
            s_q <= s_d;
    end
endmodule // burst_sliding_window

// file: burst_sliding_window_bench.sv
// self-checking bench for the burst sliding window endpoint
`timescale 1ns/1ps
module burst_sliding_window_bench;
    logic        clk = 1'h0, nrst = 1'h0, wrst = 1'h0, rxv = 1'h0;
    logic        rxok = 1'h0, upr = 1'h1, txv = 1'h0, akv = 1'h0;
    logic        start = 1'h0, slow = 1'h0, acz, upv, txr, busy, pv, pr;
    logic [3:0]  rxs = 4'h0, ps;
    logic [31:0] rxd = 32'h0, txd = 32'h0, upd, pd;
    logic [9:0]  av = 10'h000, ack;
    logic [31:0] got[$];
    int          failures = 0, checks = 0, n = 0;
    // receive rows: ok flag, sequence, mask expected once it settles
    logic [19:0] rows[12] = '{20'h1001E, 20'h1701E, 20'h0201E, 20'h1203A,
        20'h11078, 20'h140E8, 20'h131E0, 20'h153C0, 20'h16381, 20'h17303,
        20'h18207, 20'h1900F};
    // more buffers than sequence numbers lets the distance limit show
    burst_sliding_window #(.RX_BUFS(16)) dut (
        .i_sys_clk(clk), .i_nrst(nrst), .i_win_reset(wrst),
        .i_rx_valid(rxv), .i_rx_ok(rxok), .i_rx_seq(rxs), .i_rx_data(rxd),
        .o_ack_vec(ack), .o_ack_zero(acz), .o_up_valid(upv),
        .i_up_ready(upr), .o_up_data(upd), .i_tx_valid(txv),
        .o_tx_ready(txr), .i_tx_data(txd), .i_ack_valid(akv),
        .i_ack_vec(av), .i_send_start(start), .o_send_busy(busy),
        .o_pkt_valid(pv), .i_pkt_ready(pr), .o_pkt_seq(ps), .o_pkt_data(pd));
    bsw_link_peer peer (.i_sys_clk(clk), .i_slow(slow), .i_pkt_valid(pv),
        .i_pkt_seq(ps), .i_pkt_data(pd), .o_pkt_ready(pr));
    always #5 clk = ~clk;
    // words leave the fifo at the next rising edge; note them here
    always @(negedge clk)
        if (upv === 1'h1 && upr)
            got.push_back(upd);
    // ===========================================
    // shared tasks
    task automatic chk(input logic [35:0] g, input logic [35:0] e);
        checks++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rx(input logic ok, input logic [3:0] s);
        @(posedge clk);
        rxv <= 1'h1;
        rxok <= ok;
        rxs <= s;
        rxd <= {28'h0000C00, s};
        @(posedge clk);
        rxv <= 1'h0;
        repeat (6) @(posedge clk);
    endtask
    task automatic push(input logic [3:0] s);
        n = 0;
        @(posedge clk);
        txv <= 1'h1;
        txd <= {28'h0000A00, s};
        @(posedge clk);
        while (txr !== 1'h1 && n < 50)
        begin
            n++;
            @(posedge clk);
        end
        chk(txr, 1'h1);
        txv <= 1'h0;
    endtask
    task automatic ackw(input logic [9:0] v);
        @(posedge clk);
        akv <= 1'h1;
        av <= v;
        @(posedge clk);
        akv <= 1'h0;
    endtask
    // one data phase; the peer log must hold exactly the listed seqs
    task automatic send(input logic [11:0] e, input int cnt);
        peer.log_q.delete();
        n = 0;
        @(posedge clk);
        start <= 1'h1;
        @(posedge clk);
        start <= 1'h0;
        repeat (2) @(posedge clk);
        while (busy !== 1'h0 && n < 200)
        begin
            n++;
            @(posedge clk);
        end
        chk(busy, 1'h0);
        chk(peer.log_q.size(), cnt);
        for (int i = 0; i < cnt; i++)
            chk(peer.log_q[i], {e[4*i+:4], 28'h0000A00, e[4*i+:4]});
    endtask
    task automatic drained(input int s0, input int c);
        repeat (20) @(posedge clk);
        chk(got.size(), c);
        for (int i = 0; i < c; i++)
            chk(got[i], {28'h0000C00, 4'((s0 + i) % 10)});
        got.delete();
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ===========================================
    // main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        chk({pv, upv, txr, ack}, {3'h1, 10'h00F});
        nrst <= 1'h1;
        foreach (rows[i])
        begin
            rx(rows[i][16], rows[i][15:12]);
            chk(ack, rows[i][9:0]);
        end
        drained(0, 10);
        // oldest packet keeps getting lost until the distance limit
        for (int s = 1; s < 9; s++)
        begin
            rx(1'h1, 4'(s));
            if (s == 3) chk(ack, 10'h071);
            if (s == 6) chk(ack, 10'h181);
        end
        chk(ack, 10'h001);
        rx(1'h1, 4'h0);
        chk(ack, 10'h207);
        drained(0, 9);
        // stalled consumer: fill the fifo until the window closes
        upr <= 1'h0;
        for (int k = 0; k < 17; k++)
            rx(1'h1, 4'((9 + k) % 10));
        chk({acz, ack}, 11'h400);
        upr <= 1'h1;
        drained(9, 16);
        chk(ack, 10'h1E0);
        // transmit: burst, lost first packet, retry, lost ack, small window
        wrst <= 1'h1;
        @(posedge clk);
        wrst <= 1'h0;
        @(posedge clk);
        chk(ack, 10'h00F);
        push(4'h0);
        push(4'h1);
        push(4'h2);
        send(12'h210, 3);
        ackw(10'h039);
        push(4'h3);
        push(4'h4);
        send(12'h430, 3);
        slow <= 1'h1;
        send(12'h430, 3);
        ackw(10'h060);
        // a lost handshake is fetched again before any new transaction
        ackw(10'h060);
        push(4'h5);
        push(4'h6);
        @(negedge clk);
        chk(txr, 1'h0);
        send(12'h065, 2);
        // reset in mid-run: windows and sequence counters start over
        nrst <= 1'h0;
        @(negedge clk);
        chk({pv, upv, txr, busy, ack}, {4'h2, 10'h00F});
        @(posedge clk);
        nrst <= 1'h1;
        push(4'h0);
        send(12'h000, 1);
        stop_test();
    end
    // hang guard, far beyond the few hundred cycles the run needs
    initial
    begin
        #100us;
        failures++;
        stop_test();
    end
endmodule // burst_sliding_window_bench

// file: burst_sliding_window_sva.sv
// port assertions for the burst sliding window endpoint
`timescale 1ns/1ps
module bsw_sva #(
    parameter int MAX_BURST = 4,
    parameter int MAX_SEQ   = 10,
    parameter int DW        = 32,
    parameter int SW        = $clog2(MAX_SEQ)
) (
    input wire logic               i_sys_clk,
    input wire logic               i_nrst,
    input wire logic               i_win_reset,
    input wire logic               i_rx_valid,
    input wire logic               i_rx_ok,
    input wire logic [SW-1:0]      i_rx_seq,
    input wire logic [MAX_SEQ-1:0] o_ack_vec,
    input wire logic               o_ack_zero,
    input wire logic               o_up_valid,
    input wire logic               o_tx_ready,
    input wire logic               i_ack_valid,
    input wire logic               i_send_start,
    input wire logic               o_send_busy,
    input wire logic               o_pkt_valid,
    input wire logic               i_pkt_ready,
    input wire logic [SW-1:0]      o_pkt_seq,
    input wire logic [DW-1:0]      o_pkt_data
);
    localparam logic [MAX_SEQ-1:0] INIT_WIN = MAX_SEQ'((1 << MAX_BURST) - 1);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_nrst);
    // ===========================================
    // receive window
    a_zero_flag: assert property (
        o_ack_zero == (o_ack_vec == '0)) else $error("zero flag wrong");
    a_burst_cap: assert property (
        $countones(o_ack_vec) <= MAX_BURST) else $error("window too wide");
    // the config event loads the window whatever the fifo holds; the check still asks for an empty one
    a_cfg_init: assert property (
        i_win_reset && !o_up_valid |=> o_ack_vec == INIT_WIN && !o_pkt_valid)
        else $error("config event did not restore window");
    a_got_leaves: assert property (
        i_rx_valid && i_rx_ok && o_ack_vec[i_rx_seq] && !i_win_reset
        |=> !o_ack_vec[$past(i_rx_seq)]) else $error("received seq kept");
    // ===========================================
    // transmit side
    a_pkt_hold: assert property (
        o_pkt_valid && !i_pkt_ready && !i_win_reset |=> o_pkt_valid
        && $stable(o_pkt_seq) && $stable(o_pkt_data))
        else $error("packet dropped before taken");
    a_start_busy: assert property (
        i_send_start && !o_send_busy && !i_ack_valid && !i_win_reset
        |=> o_send_busy) else $error("start ignored while idle");
    a_busy_cause: assert property (
        $rose(o_send_busy) |-> $past(i_send_start))
        else $error("phase began without start");
    a_pkt_in_phase: assert property (
        $rose(o_pkt_valid) |-> $past(o_send_busy))
        else $error("packet outside data phase");
    a_seq_range: assert property (
        o_pkt_valid |-> o_pkt_seq < MAX_SEQ) else $error("seq out of range");
    a_ready_idle: assert property (
        o_tx_ready |-> !o_send_busy && !i_ack_valid)
        else $error("word taken while busy or on ack");
endmodule // bsw_sva

bind burst_sliding_window bsw_sva #(.MAX_BURST(MAX_BURST),
    .MAX_SEQ(MAX_SEQ), .DW(DW)) u_sva (.i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst), .i_win_reset(i_win_reset), .i_rx_valid(i_rx_valid),
    .i_rx_ok(i_rx_ok), .i_rx_seq(i_rx_seq), .o_ack_vec(o_ack_vec),
    .o_ack_zero(o_ack_zero), .o_up_valid(o_up_valid),
    .o_tx_ready(o_tx_ready), .i_ack_valid(i_ack_valid),
    .i_send_start(i_send_start), .o_send_busy(o_send_busy),
    .o_pkt_valid(o_pkt_valid), .i_pkt_ready(i_pkt_ready),
    .o_pkt_seq(o_pkt_seq), .o_pkt_data(o_pkt_data));
